// File: common/bio_defs.svh
// constants of the binary port: decode codes, bit positions, reset values
`ifndef BIO_DEFS_SVH
`define BIO_DEFS_SVH

`define BIO_ADDR_CTRL     3'h0
`define BIO_ADDR_STAT     3'h0
`define BIO_ADDR_OUT      3'h2
`define BIO_ADDR_IN       3'h2
`define BIO_CTL_AVAIL_BIT 0
`define BIO_CTL_REQ_BIT   1
`define BIO_STS_VALID_BIT 0
`define BIO_STS_READY_BIT 1
`define BIO_PIN_RESET     16'hFFFF
`define BIO_ZERO16        16'h0000
`define BIO_OUT_RESET     16'h0000
`define BIO_OE_N_RESET    1'b1
`define BIO_FLAG_RESET    1'b0
`define BIO_SYNC_W        20
`define BIO_SYNC_RESET    20'hFFFFF

`endif

// File: common/bio_pkg.sv
// types of the binary port: bus and pin carriers, operations, state
package bio_pkg;

   typedef enum logic [2:0] {
      BIO_OP_NONE    = 3'h0,
      BIO_OP_CTRL_WR = 3'h1,
      BIO_OP_STAT_RD = 3'h3,
      BIO_OP_OUT_WR  = 3'h2,
      BIO_OP_IN_RD   = 3'h6
   } bio_op_e;

   typedef struct packed {
      logic        device_select_strobe_n;
      logic [2:0]  word_address;
      logic        buffered_read_qualifier;
      logic [15:0] wdata;
   } bio_host_req_s;

   typedef struct packed {
      logic [15:0] rdata;
      logic        rvalid;
   } bio_host_rsp_s;

   typedef struct packed {
      logic [15:0] data;
      logic        input_latch_hold_n;
      logic        output_drive_enable;
      logic        input_data_valid;
      logic        output_ready;
   } bio_pins_in_s;

   typedef struct packed {
      logic [15:0] data;
      logic        data_oe_n;
      logic        output_data_available;
      logic        input_request;
   } bio_pins_out_s;

   typedef struct packed {
      bio_host_rsp_s rsp;
      bio_pins_out_s pins;
      logic [15:0]   latch;
   } bio_state_s;

endpackage

// File: src/bio_sync2.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/100ps

module bio_sync2 #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bio_sync_state_s;

   bio_sync_state_s st_d;
   bio_sync_state_s st_q;

   always_comb begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= {RST_VAL, RST_VAL};
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;

endmodule

// File: src/bio_port.sv
// binary input/output port with handshake flags, input hold and output gate
`timescale 1ns/100ps
`include "bio_defs.svh"

module bio_port (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire bio_pkg::bio_host_req_s host_req,
   output bio_pkg::bio_host_rsp_s      host_rsp,
   input  wire bio_pkg::bio_pins_in_s  pins_in,
   output bio_pkg::bio_pins_out_s      pins_out
);
   import bio_pkg::*;

   localparam bio_state_s ST_RST = '{
      rsp:   '{rdata: `BIO_ZERO16, rvalid: 1'b0},
      pins:  '{data: `BIO_OUT_RESET, data_oe_n: `BIO_OE_N_RESET,
               output_data_available: `BIO_FLAG_RESET, input_request: `BIO_FLAG_RESET},
      latch: `BIO_PIN_RESET
   };

   bio_pins_in_s pins_s;
   bio_state_s   st_d;
   bio_state_s   st_q;
   bio_op_e      op;

   // pins pass two flops; reset to ones as the pull-ups would
   bio_sync2 #(
      .W       (`BIO_SYNC_W),
      .RST_VAL (`BIO_SYNC_RESET)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (pins_in),
      .q     (pins_s)
   );

   function automatic bio_op_e decode(input bio_host_req_s r);
      decode = BIO_OP_NONE;
      if (!r.device_select_strobe_n) begin
         if (r.word_address == `BIO_ADDR_CTRL && !r.buffered_read_qualifier) begin
            decode = BIO_OP_CTRL_WR;
         end
         if (r.word_address == `BIO_ADDR_STAT && r.buffered_read_qualifier) begin
            decode = BIO_OP_STAT_RD;
         end
         if (r.word_address == `BIO_ADDR_OUT && !r.buffered_read_qualifier) begin
            decode = BIO_OP_OUT_WR;
         end
         if (r.word_address == `BIO_ADDR_IN && r.buffered_read_qualifier) begin
            decode = BIO_OP_IN_RD;
         end
      end
   endfunction

   function automatic logic [15:0] status_word(input bio_pins_in_s p);
      status_word = `BIO_ZERO16;
      status_word[`BIO_STS_VALID_BIT] = p.input_data_valid;
      status_word[`BIO_STS_READY_BIT] = p.output_ready;
   endfunction

   assign op = decode(host_req);

   always_comb begin
      st_d = st_q;
      st_d.rsp.rvalid = 1'b0;
      // flags play no part in the pin paths below
      if (pins_s.input_latch_hold_n) begin
         st_d.latch = pins_s.data;
      end
      st_d.pins.data_oe_n = ~pins_s.output_drive_enable;
      unique case (op)
         BIO_OP_CTRL_WR: begin
            st_d.pins.output_data_available = host_req.wdata[`BIO_CTL_AVAIL_BIT];
            st_d.pins.input_request = host_req.wdata[`BIO_CTL_REQ_BIT];
         end
         BIO_OP_STAT_RD: begin
            st_d.rsp.rdata = status_word(pins_s);
            st_d.rsp.rvalid = 1'b1;
         end
         BIO_OP_OUT_WR: begin
            st_d.pins.data = host_req.wdata;
         end
         BIO_OP_IN_RD: begin
            st_d.rsp.rdata = st_q.latch;
            st_d.rsp.rvalid = 1'b1;
         end
         BIO_OP_NONE: begin
            if (!host_req.device_select_strobe_n && host_req.buffered_read_qualifier) begin
               st_d.rsp.rdata = `BIO_ZERO16;
               st_d.rsp.rvalid = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign host_rsp = st_q.rsp;
   assign pins_out = st_q.pins;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_hold_drop;
      pins_s.input_latch_hold_n ##1 !pins_s.input_latch_hold_n;
   endsequence

   sequence s_out_write;
      op == BIO_OP_OUT_WR;
   endsequence

   AST_SELECT_ONLY: assert property (
      host_rsp.rvalid |-> $past(!host_req.device_select_strobe_n))
      else $error("answer without device select");

   AST_CTRL_WRITE: assert property (
      op == BIO_OP_CTRL_WR |=> pins_out.output_data_available == $past(host_req.wdata[`BIO_CTL_AVAIL_BIT])
         && pins_out.input_request == $past(host_req.wdata[`BIO_CTL_REQ_BIT]))
      else $error("control flags not latched");

   AST_STATUS_READ: assert property (
      op == BIO_OP_STAT_RD |=> host_rsp.rvalid && host_rsp.rdata == status_word($past(pins_s)))
      else $error("status read wrong");

   AST_OUT_WRITE: assert property (
      s_out_write |=> pins_out.data == $past(host_req.wdata) ##1 pins_out.data == $past(pins_out.data)
         || $past(op) == BIO_OP_OUT_WR)
      else $error("output word not stored");

   AST_IN_READ: assert property (
      op == BIO_OP_IN_RD |=> host_rsp.rvalid && host_rsp.rdata == $past(st_q.latch))
      else $error("input read wrong");

   AST_TRANSPARENT: assert property (
      pins_s.input_latch_hold_n |=> st_q.latch == $past(pins_s.data))
      else $error("input register not transparent");

   AST_HOLD: assert property (
      s_hold_drop |=> st_q.latch == $past(st_q.latch) ##1 (pins_s.input_latch_hold_n
         || $past(pins_s.input_latch_hold_n) || st_q.latch == $past(st_q.latch)))
      else $error("held value changed");

   AST_GATE: assert property (
      $past(rst_n) |-> pins_out.data_oe_n == $past(!pins_s.output_drive_enable))
      else $error("output gate not followed");

   AST_NO_GLITCH: assert property (
      op != BIO_OP_OUT_WR |=> $stable(pins_out.data))
      else $error("output bits changed without a write");

   AST_FLAGS_FREE: assert property (
      op == BIO_OP_CTRL_WR && pins_s.input_latch_hold_n |=> st_q.latch == $past(pins_s.data))
      else $error("control write disturbed input path");

endmodule

// File: testbench/bio_far.sv
// far TTL device model for the binary port
`timescale 1ns/100ps

module bio_far (
   input  wire logic        clk,
   input  wire logic        req,
   input  wire logic        avail,
   input  wire logic [15:0] out,
   input  wire logic [15:0] word,
   output logic      [15:0] data,
   output logic             valid,
   output logic             ready,
   output logic      [15:0] got
);
   always_ff @(posedge clk) begin
      data  <= req ? word : 16'hFFFF;
      valid <= req;
      ready <= ~avail;
      if (avail) begin
         got <= out;
      end
   end
endmodule

// File: testbench/bio_port_bench.sv
// self-checking bench of the binary port
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
 $display("FAIL %s exp %h got %h", n, e, a); end end

module bio_port_bench;
   import bio_pkg::*;
   logic          clk = 0;
   logic          rst_n = 0;
   logic          hold_n = 1;
   logic          gate = 1;
   logic [15:0]   word = 16'h0000;
   logic [15:0]   got, fdata;
   logic          fvalid, fready;
   int            n_mismatch = 0;
   int            check_count = 0;
   int            cyc = 0;
   bio_host_req_s req = '{1'b1, 3'h0, 1'b0, 16'h0000};
   bio_host_rsp_s rsp;
   bio_pins_out_s po;
   bio_pins_in_s  pi;
   assign pi = '{fdata, hold_n, gate, fvalid, fready};
   bio_port dut (.clk(clk), .rst_n(rst_n), .host_req(req), .host_rsp(rsp), .pins_in(pi), .pins_out(po));
   bio_far far (.clk(clk), .req(po.input_request), .avail(po.output_data_available),
                .out(po.data_oe_n ? 16'hFFFF : po.data),
                .word(word), .data(fdata), .valid(fvalid), .ready(fready), .got(got));
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic acc(input logic [2:0] a, input logic r, input logic [15:0] w);
      @(posedge clk) req <= '{1'b0, a, r, w};
      @(posedge clk) req.device_select_strobe_n <= 1'b1;
      #1;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_reset();
      `CHK("out reset", 16'h0000, po.data);
      wt(4);
      `CHK("oe_n gate high", 1'b0, po.data_oe_n);
      acc(3'h2, 1'b1, 16'h0000);
      `CHK("rvalid", 1'b1, rsp.rvalid);
      `CHK("float input", 16'hFFFF, rsp.rdata);
      acc(3'h5, 1'b1, 16'h0000);
      `CHK("unmapped", 16'h0000, rsp.rdata);
      $display("test reset done");
   endtask
   task automatic t_out();
      acc(3'h2, 1'b0, 16'hA55A);
      `CHK("out word", 16'hA55A, po.data);
      acc(3'h2, 1'b0, 16'hA55B);
      `CHK("out bit", 16'hA55B, po.data);
      @(posedge clk) req <= '{1'b1, 3'h2, 1'b0, 16'h1234};
      wt(2);
      `CHK("no select", 16'hA55B, po.data);
      @(posedge clk) gate <= 1'b0;
      wt(4);
      `CHK("gate low", 1'b1, po.data_oe_n);
      @(posedge clk) gate <= 1'b1;
      wt(4);
      `CHK("gate high", 1'b0, po.data_oe_n);
      $display("test out done");
   endtask
   task automatic t_hand();
      word <= 16'hBEEF;
      acc(3'h0, 1'b0, 16'h0003);
      `CHK("flags", 2'h3, {po.input_request, po.output_data_available});
      wt(6);
      acc(3'h0, 1'b1, 16'h0000);
      `CHK("status set", 16'h0001, rsp.rdata);
      acc(3'h2, 1'b1, 16'h0000);
      `CHK("input word", 16'hBEEF, rsp.rdata);
      `CHK("far took", 16'hA55B, got);
      acc(3'h0, 1'b0, 16'h0000);
      `CHK("flags off", 2'h0, {po.input_request, po.output_data_available});
      acc(3'h2, 1'b0, 16'h0F0F);
      `CHK("out flags off", 16'h0F0F, po.data);
      wt(6);
      acc(3'h0, 1'b1, 16'h0000);
      `CHK("status clr", 16'h0002, rsp.rdata);
      $display("test handshake done");
   endtask
   task automatic t_hold();
      word <= 16'h1111;
      acc(3'h0, 1'b0, 16'h0002);
      wt(6);
      @(posedge clk) hold_n <= 1'b0;
      wt(4);
      @(posedge clk) word <= 16'h2222;
      wt(6);
      acc(3'h2, 1'b1, 16'h0000);
      `CHK("held", 16'h1111, rsp.rdata);
      @(posedge clk) hold_n <= 1'b1;
      wt(6);
      acc(3'h2, 1'b1, 16'h0000);
      `CHK("released", 16'h2222, rsp.rdata);
      $display("test hold done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      wt(1);
      t_reset();
      t_out();
      t_hand();
      t_hold();
      summarize();
   end
endmodule
